// >>> bench/dtc_field_model.sv
/*
 * field side model of one counter: clock, direction and two ext pins.
 * assumes the bench calls its tasks just after a rising clock edge.
 */
`timescale 1ns/10ps
`default_nettype none
module dtc_field_model (
    input  wire logic         i_clk,   // system clock, paces the pins
    output var dtc_pkg::pins_t o_pins  // pins seen by the counter
);
    import dtc_pkg::*;

    // pins idle low, no pulls on the field lines
    initial o_pins = '0;

    // each level stands 4 clocks so the two-flop sync cannot miss it
    task automatic hold4;
        repeat (4) @(posedge i_clk);
    endtask : hold4

    // set one pin (0 clk, 1 dir, 2..3 ext) and let it settle
    task automatic set(input int b, input logic v);
        o_pins[b] <= v;
        hold4();
    endtask : set

    // n whole pulses on clk or dir pin
    task automatic pulse(input int b, input int n);
        repeat (n) begin
            set(b, 1'b1);
            set(b, 1'b0);
        end
    endtask : pulse

    // n full quadrature cycles, phase a leading when fwd
    task automatic quad(input bit fwd, input int n);
        repeat (n) begin
            set(fwd ? 0 : 1, 1'b1);
            set(fwd ? 1 : 0, 1'b1);
            set(fwd ? 0 : 1, 1'b0);
            set(fwd ? 1 : 0, 1'b0);
        end
    endtask : quad
endmodule : dtc_field_model
`default_nettype wire

// >>> bench/tb_dual_totalizer_counter.sv
/*
 * self-checking bench: apb host tasks plus two field pin models.
 * assumes one wait cycle per apb transfer is not relied on; waits are bounded.
 */
`timescale 1ns/10ps
`default_nettype none
module tb_dual_totalizer_counter;
    import dtc_pkg::*;

    logic        clk_sys = 1'b0;  // 200 mhz clock
    logic        rst_n   = 1'b0;  // active low reset
    apb_req_t    apb     = '0;    // host request group
    pins_t       fa;              // counter a pins
    pins_t       fb;              // counter b pins
    logic [31:0] prdata;          // read data
    logic        pready;          // transfer done
    logic        pslverr;         // refused transfer
    logic [31:0] rd;              // last read data
    logic        err;             // last error flag
    int          mismatches   = 0;
    int          total_checks = 0;

    dual_totalizer_counter i_dut (
        .I_CLK_SYS (clk_sys),
        .I_RST_N   (rst_n),
        .I_APB     (apb),
        .I_FIELD_A (fa),
        .I_FIELD_B (fb),
        .O_PRDATA  (prdata),
        .O_PREADY  (pready),
        .O_PSLVERR (pslverr)
    );
    dtc_field_model i_fa (.i_clk(clk_sys), .o_pins(fa));
    dtc_field_model i_fb (.i_clk(clk_sys), .o_pins(fb));

    // free running clock, 5 ns period
    initial forever #2.5 clk_sys = ~clk_sys;

    // verdict and end of run, reached from the main flow or a timeout
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : summarize

    // one apb transfer; request held until pready is sampled high
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        apb.psel    <= 1'b1;
        apb.penable <= 1'b0;
        apb.pwrite  <= w;
        apb.paddr   <= a;
        apb.pwdata  <= d;
        @(posedge clk_sys);
        apb.penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd  = prdata;
        err = pslverr;
        apb.psel    <= 1'b0;
        apb.penable <= 1'b0;
        if (n >= 20) begin
            mismatches++;
            summarize();
        end
    endtask : acc

    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask : cmp

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        acc(1'b1, a, d);
    endtask : wr

    task automatic chk(input logic [7:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        cmp(rd, e);
    endtask : chk

    // main sequence; pulses run with the bus idle, so counting needs no host
    initial begin
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        chk(OFS_CNT_A, 32'h0);
        chk(OFS_CTRL_A, 32'h0);
        wr(OFS_CFG_B, 32'hffffffff);
        chk(OFS_CFG_B, 32'h3ff);       // top config bit is not writable
        wr(OFS_CFG_B, 32'h0);
        wr(OFS_CNT_A, 32'h5);          // read-only place refuses
        cmp({31'h0, err}, 32'h1);
        chk(OFS_CNT_A, 32'h0);
        chk(8'h40, 32'h0);             // unmapped place reads zero
        cmp({31'h0, err}, 32'h1);
        // totalizer, direction from pin
        wr(OFS_CFG_A, 32'h1);
        wr(OFS_CTRL_A, 32'h8);
        i_fa.set(1, 1'b1);
        i_fa.pulse(0, 3);
        chk(OFS_CNT_A, 32'h3);
        i_fa.set(1, 1'b0);
        i_fa.pulse(0, 4);
        chk(OFS_CNT_A, 32'hffffffff);
        // latch held high: one snapshot, counting goes on
        wr(OFS_CTRL_A, 32'ha);
        i_fa.pulse(0, 2);
        chk(OFS_SNAP_A, 32'hffffffff);
        chk(OFS_CNT_A, 32'hfffffffd);
        wr(OFS_CTRL_A, 32'h0);
        i_fa.pulse(0, 2);
        chk(OFS_CNT_A, 32'hfffffffd);
        // load held, then released near the top
        wr(OFS_LOAD_A, 32'hfffffffe);
        wr(OFS_CTRL_A, 32'h9);
        i_fa.set(1, 1'b1);
        i_fa.pulse(0, 2);
        chk(OFS_CNT_A, 32'hfffffffe);
        wr(OFS_CTRL_A, 32'h8);
        i_fa.pulse(0, 3);
        chk(OFS_CNT_A, 32'h1);
        wr(OFS_CTRL_A, 32'hd);
        i_fa.pulse(0, 1);
        chk(OFS_CNT_A, 32'h0);
        // host direction bit overrides the high dir pin
        wr(OFS_CFG_A, 32'h9);
        wr(OFS_CTRL_A, 32'h8);
        i_fa.pulse(0, 1);
        chk(OFS_CNT_A, 32'hffffffff);
        wr(OFS_CTRL_A, 32'h18);
        i_fa.pulse(0, 2);
        chk(OFS_CNT_A, 32'h1);
        // ext pin 0 acts as clear, host keeps enable
        wr(OFS_CFG_A, 32'h111);
        i_fa.set(2, 1'b1);
        i_fa.pulse(0, 1);
        chk(OFS_CNT_A, 32'h0);
        i_fa.set(2, 1'b0);
        i_fa.pulse(0, 1);
        chk(OFS_CNT_A, 32'h1);
        // quadrature, 4x decode
        i_fa.set(1, 1'b0);
        wr(OFS_CFG_A, 32'h5);
        i_fa.quad(1'b1, 2);
        chk(OFS_CNT_A, 32'h9);
        i_fa.quad(1'b0, 1);
        chk(OFS_CNT_A, 32'h5);
        // up/down on b, a untouched
        wr(OFS_CFG_B, 32'h3);
        wr(OFS_CTRL_B, 32'h8);
        i_fb.pulse(0, 3);
        i_fb.pulse(1, 1);
        chk(OFS_CNT_B, 32'h2);
        chk(OFS_CNT_A, 32'h5);
        // timer up then down, about ten ticks in 200 clocks
        for (int t = 0; t < 2; t++) begin
            wr(OFS_CFG_B, t ? 32'h47 : 32'h27);
            wr(OFS_CTRL_B, 32'hc);
            wr(OFS_CTRL_B, 32'h8);
            repeat (200) @(posedge clk_sys);
            acc(1'b0, OFS_CNT_B, 32'h0);
            rd = t ? 32'h0 - rd : rd;
            cmp((rd >= 32'h9 && rd <= 32'hb) ? 32'ha : rd, 32'ha);
        end
        summarize();
    end
endmodule : tb_dual_totalizer_counter
`default_nettype wire

// >>> core/dtc_channel.sv
/*
 * one 32-bit counter: edge detection, mode decode, clear/load/count and snapshot.
 * assumes pins already synchronised and controls already resolved by the caller.
 */
`timescale 1ns/10ps
`default_nettype none
module dtc_channel (
    input  wire logic            i_clk,
    input  wire logic            i_rst_n,
    input  wire dtc_pkg::pins_t  i_pins,     // synchronised field pins
    input  wire dtc_pkg::cfg_t   i_cfg,      // channel configuration
    input  wire dtc_pkg::ctrl_t  i_ctl,      // resolved controls and direction
    input  wire logic [31:0]     i_load_val, // preset value
    input  wire logic            i_tick,     // 10 mhz enable pulse
    output logic [31:0]          o_count,
    output logic [31:0]          o_snap
);
    import dtc_pkg::*;

    typedef struct packed {
        logic             clk_p;  // previous count clock
        logic             dir_p;  // previous direction pin
        logic             lat_p;  // previous latch control
        logic [CNT_W-1:0] cnt;    // live count
        logic [CNT_W-1:0] snap;   // read register
    } ch_state_t;

    ch_state_t st_ff, nxt_st;
    logic      rise_clk, rise_dir, lat_rise, step_up, step_dn, run, mv, tdir;

    // decode one step per qualifying edge, then apply priorities
    always_comb begin
        nxt_st   = st_ff;
        rise_clk = i_pins.clk & ~st_ff.clk_p;              // [RULE_20]
        rise_dir = i_pins.dir & ~st_ff.dir_p;
        lat_rise = i_ctl.lat & ~st_ff.lat_p;
        mv       = (i_pins.clk ^ st_ff.clk_p) ^ (i_pins.dir ^ st_ff.dir_p);
        tdir     = 1'b1;
        step_up  = 1'b0;
        step_dn  = 1'b0;
        case (i_cfg.mode)                                   // [RULE_03]
            MODE_TOTAL: begin                               // [RULE_04]
                step_up = rise_clk & i_ctl.dir;
                step_dn = rise_clk & ~i_ctl.dir;
            end
            MODE_UPDN: begin                                // [RULE_10]
                // simultaneous up and down edges cancel
                step_up = rise_clk & ~rise_dir;
                step_dn = rise_dir & ~rise_clk;
            end
            MODE_QUAD: begin                                // [RULE_11]
                // a leading b counts up; a double change is invalid and skipped
                step_up = mv & (i_pins.clk ^ st_ff.dir_p);
                step_dn = mv & ~(i_pins.clk ^ st_ff.dir_p);
            end
            MODE_TIMER: begin                               // [RULE_12]
                case (i_cfg.tmr_dir)                        // [RULE_13]
                    TDIR_INPUT: tdir = i_ctl.dir;
                    TDIR_DOWN:  tdir = 1'b0;
                    default:    tdir = 1'b1;
                endcase
                step_up = i_tick & tdir;
                step_dn = i_tick & ~tdir;
            end
            default: begin
                step_up = 1'b0;
            end
        endcase
        // no host idle input exists: only enable, or a held clear or load, can stop the count
        run = i_cfg.en & i_ctl.en;                          // [RULE_01] [RULE_09] [RULE_16]
        nxt_st.clk_p = i_pins.clk;
        nxt_st.dir_p = i_pins.dir;
        nxt_st.lat_p = i_ctl.lat;
        if (i_ctl.clr) begin                                // [RULE_07] [RULE_17] [RULE_19]
            nxt_st.cnt = '0;
        end else if (i_ctl.ld) begin                        // [RULE_05]
            nxt_st.cnt = i_load_val;
        end else if (run & step_up) begin                   // [RULE_06]
            nxt_st.cnt = st_ff.cnt + 32'h1;
        end else if (run & step_dn) begin
            nxt_st.cnt = st_ff.cnt - 32'h1;
        end
        if (lat_rise) begin                                 // [RULE_08] [RULE_18]
            nxt_st.snap = st_ff.cnt;
        end
    end

    // state register
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_count = st_ff.cnt;
    assign o_snap  = st_ff.snap;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    a_clear_zero: assert property (i_ctl.clr |=> st_ff.cnt == 32'h0) // [RULE_17]
        else $error("count not zero after clear");
    a_load_wins: assert property (i_ctl.ld && !i_ctl.clr |=> st_ff.cnt == $past(i_load_val)) // [RULE_05]
        else $error("load value not taken");
    a_clear_first: assert property (i_ctl.clr && i_ctl.ld |=> st_ff.cnt == 32'h0) // [RULE_19]
        else $error("load beat clear");
    a_hold_off: assert property (!run && !i_ctl.clr && !i_ctl.ld |=> $stable(st_ff.cnt)) // [RULE_09]
        else $error("count moved while disabled");
    a_snap_take: assert property (lat_rise |=> st_ff.snap == $past(st_ff.cnt)) // [RULE_18]
        else $error("snapshot missed");
    a_snap_keep: assert property (!lat_rise |=> $stable(st_ff.snap)) // [RULE_08]
        else $error("snapshot changed without latch edge");
    a_wrap_down: assert property (run && step_dn && !i_ctl.clr && !i_ctl.ld
        && st_ff.cnt == 32'h0 |=> st_ff.cnt == 32'hffffffff) // [RULE_06]
        else $error("down count did not wrap");
    a_total_up: assert property (i_cfg.mode == MODE_TOTAL && run && rise_clk && i_ctl.dir
        && !i_ctl.clr && !i_ctl.ld |=> st_ff.cnt == $past(st_ff.cnt) + 32'h1) // [RULE_04]
        else $error("totalizer missed an up count");
endmodule : dtc_channel
`default_nettype wire

// >>> core/dual_totalizer_counter.sv
/*
 * dual 32-bit counter block with an apb register slave and a 10 mhz time base.
 * assumes field pins are asynchronous to the 200 mhz system clock and that
 * the apb master keeps a request steady until it sees pready high.
 */
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// RULE_01 - two 32-bit counters, separately enabled and moded
// RULE_02 - counting excludes frequency measurement on counters
// RULE_03 - each counter runs one of four modes
// RULE_04 - totalizer: clock edge counts, direction sets sign
// RULE_05 - load high forces and holds preset value
// RULE_06 - count wraps at zero and at modulus
// RULE_07 - clear sets count to zero
// RULE_08 - latch snapshots count into read register
// RULE_09 - enable low holds the count
// RULE_10 - up/down: clock counts up, direction counts down
// RULE_11 - quadrature: leading phase sets the direction
// RULE_12 - timer counts internal 10 MHz ticks
// RULE_13 - timer direction from input or fixed setting
// RULE_14 - controls from host, or two from field
// RULE_15 - direction from field pin or host bit
// RULE_16 - counting continues while host idles
// RULE_17 - clear is level: zero while held
// RULE_18 - snapshot only on latch rising edge
// RULE_19 - clear beats load, both beat counting
// RULE_20 - inputs synchronised, one count per edge
module dual_totalizer_counter (
    input  wire logic              I_CLK_SYS,   // 200 mhz system clock
    input  wire logic              I_RST_N,     // asynchronous reset
    input  wire dtc_pkg::apb_req_t I_APB,       // apb request group
    input  wire dtc_pkg::pins_t    I_FIELD_A,   // counter a field pins
    input  wire dtc_pkg::pins_t    I_FIELD_B,   // counter b field pins
    output logic [31:0]            O_PRDATA,    // read data
    output logic                   O_PREADY,    // transfer done
    output logic                   O_PSLVERR    // unmapped or read-only write
);
    import dtc_pkg::*;

    // whole module state in one record
    typedef struct packed {
        pins_t [NUM_CH-1:0]             s1;     // first sync stage
        pins_t [NUM_CH-1:0]             s2;     // second sync stage
        cfg_t  [NUM_CH-1:0]             cfg;    // configuration words
        ctrl_t [NUM_CH-1:0]             ctrl;   // host control words
        logic  [NUM_CH-1:0][CNT_W-1:0]  load;   // preset values
        logic  [4:0]                    tdiv;   // time base divider
        logic                           tick;   // 10 mhz enable pulse
        logic  [31:0]                   prdata; // registered read data
        logic                           pready; // registered ready
        logic                           pslverr;
    } top_state_t;

    top_state_t                    st_ff;       // registered state
    top_state_t                    nxt_st;      // next state
    ctrl_t [NUM_CH-1:0]            ctl_res;     // resolved controls per counter
    logic  [NUM_CH-1:0][CNT_W-1:0] cnt_w;       // live counts
    logic  [NUM_CH-1:0][CNT_W-1:0] snap_w;      // snapshot registers
    logic                          acc;         // access phase, answer pending
    logic                          commit;      // transfer completes this edge
    logic                          hit;         // address decodes to a register
    logic                          ro;          // address is read-only
    logic  [31:0]                  rd;          // read mux

    // merge host and field controls for one counter
    function automatic ctrl_t resolve(input ctrl_t host, input cfg_t c, input pins_t p);
        ctrl_t r;
        r = host;
        if (c.ctl_ext) begin                                // [RULE_14]
            // each field input replaces the control its selector names;
            // if both name the same control, input 1 wins
            case (c.ext0_sel)
                SEL_LOAD:  r.ld  = p.ext[0];
                SEL_LATCH: r.lat = p.ext[0];
                SEL_CLEAR: r.clr = p.ext[0];
                default:   r.en  = p.ext[0];
            endcase
            case (c.ext1_sel)
                SEL_LOAD:  r.ld  = p.ext[1];
                SEL_LATCH: r.lat = p.ext[1];
                SEL_CLEAR: r.clr = p.ext[1];
                default:   r.en  = p.ext[1];
            endcase
        end
        r.dir = c.dir_reg ? host.dir : p.dir;               // [RULE_15]
        return r;
    endfunction : resolve

    // field controls come only from the second sync stage; host controls from the control words
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            ctl_res[i] = resolve(st_ff.ctrl[i], st_ff.cfg[i], st_ff.s2[i]);
        end
    end

    // apb phase decode
    assign acc    = I_APB.psel & I_APB.penable & ~st_ff.pready;
    assign commit = I_APB.psel & I_APB.penable & st_ff.pready;

    // read mux and address classification
    always_comb begin
        rd  = 32'h0;
        hit = 1'b1;
        ro  = 1'b0;
        case (I_APB.paddr)
            OFS_CFG_A:  rd = 32'(st_ff.cfg[0]);
            OFS_CFG_B:  rd = 32'(st_ff.cfg[1]);
            OFS_CTRL_A: rd = 32'(st_ff.ctrl[0]);
            OFS_CTRL_B: rd = 32'(st_ff.ctrl[1]);
            OFS_LOAD_A: rd = st_ff.load[0];
            OFS_LOAD_B: rd = st_ff.load[1];
            OFS_CNT_A: begin                                // live count
                rd = cnt_w[0];
                ro = 1'b1;
            end
            OFS_CNT_B: begin
                rd = cnt_w[1];
                ro = 1'b1;
            end
            OFS_SNAP_A: begin                               // latched count
                rd = snap_w[0];
                ro = 1'b1;
            end
            OFS_SNAP_B: begin
                rd = snap_w[1];
                ro = 1'b1;
            end
            default: begin                                  // unmapped
                hit = 1'b0;
            end
        endcase
    end

    // next state: synchronisers, divider, apb slave
    always_comb begin
        nxt_st = st_ff;
        // two flops on every field pin before any logic reads it
        nxt_st.s1[0] = I_FIELD_A;                           // [RULE_20]
        nxt_st.s1[1] = I_FIELD_B;
        nxt_st.s2    = st_ff.s1;
        // free-running divider; never gated by the host state
        if (st_ff.tdiv == TICK_LAST) begin                  // [RULE_12] [RULE_16]
            nxt_st.tdiv = 5'h0;
            nxt_st.tick = 1'b1;
        end else begin
            nxt_st.tdiv = st_ff.tdiv + 5'h1;
            nxt_st.tick = 1'b0;
        end
        // answer one cycle into the access phase
        nxt_st.pready = 1'b0;
        if (acc) begin
            nxt_st.pready  = 1'b1;
            nxt_st.prdata  = I_APB.pwrite ? 32'h0 : rd;
            nxt_st.pslverr = ~hit | (I_APB.pwrite & ro);
        end
        // writes land on the completing edge only
        if (commit && I_APB.pwrite && !st_ff.pslverr) begin
            case (I_APB.paddr)
                // no frequency-measure field exists; counting is the only function
                // top selector bit has no bus lane: it always loads zero
                OFS_CFG_A:  nxt_st.cfg[0]  = cfg_t'({1'b0, I_APB.pwdata[CFG_W-1:0]}); // [RULE_02]
                OFS_CFG_B:  nxt_st.cfg[1]  = cfg_t'({1'b0, I_APB.pwdata[CFG_W-1:0]});
                OFS_CTRL_A: nxt_st.ctrl[0] = ctrl_t'(I_APB.pwdata[CTRL_W-1:0]);
                OFS_CTRL_B: nxt_st.ctrl[1] = ctrl_t'(I_APB.pwdata[CTRL_W-1:0]);
                OFS_LOAD_A: nxt_st.load[0] = I_APB.pwdata;
                OFS_LOAD_B: nxt_st.load[1] = I_APB.pwdata;
                default: begin                              // read-only: already refused
                    nxt_st.tick = nxt_st.tick;
                end
            endcase
        end
    end

    // state register; reset loads constants only
    always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) begin
            st_ff      <= '0;
            st_ff.cfg  <= {NUM_CH{CFG_RST}};
            st_ff.ctrl <= {NUM_CH{CTRL_RST}};
            st_ff.load <= {NUM_CH{LOAD_RST}};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // two identical counters, each with its own mode and enable
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch       // [RULE_01]
        dtc_channel u_ch (
            .i_clk      (I_CLK_SYS),
            .i_rst_n    (I_RST_N),
            .i_pins     (st_ff.s2[g]),
            .i_cfg      (st_ff.cfg[g]),
            .i_ctl      (ctl_res[g]),
            .i_load_val (st_ff.load[g]),
            .i_tick     (st_ff.tick),
            .o_count    (cnt_w[g]),
            .o_snap     (snap_w[g])
        );
    end

    // outputs straight from flops
    assign O_PRDATA  = st_ff.prdata;
    assign O_PREADY  = st_ff.pready;
    assign O_PSLVERR = st_ff.pslverr;

    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RST_N);

    // one tick followed by nineteen quiet cycles
    sequence s_tick_gap;
        !st_ff.tick [*8] ##1 !st_ff.tick [*8] ##1 !st_ff.tick [*3];
    endsequence

    a_tick_period: assert property (st_ff.tick |=> s_tick_gap ##1 st_ff.tick) // [RULE_12]
        else $error("time base tick period wrong");

    a_apb_answer: assert property (acc |=> O_PREADY ##1 !O_PREADY)
        else $error("apb answer not one cycle");

    a_apb_unmapped: assert property (acc && !hit |=> O_PSLVERR)
        else $error("unmapped address not flagged");

    a_load_write: assert property (commit && I_APB.pwrite && !O_PSLVERR
        && I_APB.paddr == OFS_LOAD_A |=> st_ff.load[0] == $past(I_APB.pwdata)) // [RULE_05]
        else $error("load value write lost");

    a_field_clear: assert property (st_ff.cfg[0].ctl_ext && st_ff.cfg[0].ext0_sel == SEL_CLEAR
        && st_ff.cfg[0].ext1_sel != SEL_CLEAR |-> ctl_res[0].clr == st_ff.s2[0].ext[0]) // [RULE_14]
        else $error("field clear not routed");

    a_dir_source: assert property (!st_ff.cfg[1].dir_reg
        |-> ctl_res[1].dir == st_ff.s2[1].dir) // [RULE_15]
        else $error("direction source wrong");

    a_pin_latency: assert property ($rose(I_FIELD_A.clk) ##1 I_FIELD_A.clk
        |=> st_ff.s2[0].clk) // [RULE_20]
        else $error("pin sync latency wrong");
endmodule : dual_totalizer_counter
`default_nettype wire

// >>> shared/dtc_pkg.sv
/*
 * constants, encodings and carrier types shared by the dual counter block.
 * assumes a 200 MHz system clock and a 32-bit apb master with 8-bit addresses.
 */
package dtc_pkg;
    localparam int CNT_W          = 32;   // counter width
    localparam int NUM_CH         = 2;    // two independent counters
    localparam int CLK_PERIOD_NS  = 5;    // system clock period
    localparam int TICK_PERIOD_NS = 100;  // internal 10 mhz time base
    localparam int TICK_DIV       = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [4:0] TICK_LAST = 5'(TICK_DIV - 1);

    // register byte offsets, one aligned word each
    localparam logic [7:0] OFS_CFG_A  = 8'h00;
    localparam logic [7:0] OFS_CFG_B  = 8'h04;
    localparam logic [7:0] OFS_CTRL_A = 8'h08;
    localparam logic [7:0] OFS_CTRL_B = 8'h0c;
    localparam logic [7:0] OFS_LOAD_A = 8'h10;
    localparam logic [7:0] OFS_LOAD_B = 8'h14;
    localparam logic [7:0] OFS_CNT_A  = 8'h18;
    localparam logic [7:0] OFS_CNT_B  = 8'h1c;
    localparam logic [7:0] OFS_SNAP_A = 8'h20;
    localparam logic [7:0] OFS_SNAP_B = 8'h24;

    localparam int CFG_W  = 10;           // writable bits of a config word
    localparam int CTRL_W = 5;            // used bits of a control word

    typedef enum logic [1:0] {MODE_TOTAL, MODE_UPDN, MODE_QUAD, MODE_TIMER} mode_t;
    typedef enum logic [1:0] {SEL_LOAD, SEL_LATCH, SEL_CLEAR, SEL_ENABLE} ctl_sel_t;
    typedef enum logic [1:0] {TDIR_INPUT, TDIR_UP, TDIR_DOWN, TDIR_UP2} tmr_dir_t;

    typedef struct packed {
        ctl_sel_t ext1_sel;   // [10:9] control taken from field input 1
        ctl_sel_t ext0_sel;   // [8:7] control taken from field input 0
        tmr_dir_t tmr_dir;    // [6:5] timer direction source
        logic     ctl_ext;    // [4]   two controls from field inputs
        logic     dir_reg;    // [3]   direction from host bit
        mode_t    mode;       // [2:1] input mode
        logic     en;         // [0]   counter enabled by configuration
    } cfg_t;

    typedef struct packed {
        logic dir;            // [4] host direction bit
        logic en;             // [3] enable
        logic clr;            // [2] clear
        logic lat;            // [1] latch
        logic ld;             // [0] load
    } ctrl_t;

    typedef struct packed {
        logic [1:0] ext;      // two field control inputs
        logic       dir;      // direction / count down / phase b
        logic       clk;      // clock / count up / phase a
    } pins_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    localparam cfg_t        CFG_RST  = '0;
    localparam ctrl_t       CTRL_RST = '0;
    localparam logic [31:0] LOAD_RST = 32'h0;
endpackage : dtc_pkg
